// ---- hw/etac_pkg.sv ----
// Register map, field positions and timing constants of the EEPROM timebase control
package etac_pkg;
  localparam int NARR = 2;

  // Register offsets, index 0 is array 1, index 1 is array 2
  localparam logic [15:0]       MOPT_OFS = 16'hFE09;
  localparam logic [1:0][15:0]  DIVHS_OFS = {16'hFF70, 16'hFE10};
  localparam logic [1:0][15:0]  DIVLS_OFS = {16'hFF71, 16'hFE11};
  localparam logic [1:0][15:0]  DIVH_OFS = {16'hFF7A, 16'hFE1A};
  localparam logic [1:0][15:0]  DIVL_OFS = {16'hFF7B, 16'hFE1B};
  localparam logic [1:0][15:0]  CFGS_OFS = {16'hFF7C, 16'hFE1C};
  localparam logic [1:0][15:0]  CTRL_OFS = {16'hFF7D, 16'hFE1D};
  localparam logic [1:0][15:0]  CFGA_OFS = {16'hFF7F, 16'hFE1F};
  localparam logic [15:0]       IST_OFS = 16'hFE12;
  localparam logic [15:0]       ICLR_OFS = 16'hFE13;
  localparam logic [15:0]       IEN_OFS = 16'hFE14;

  // Field positions
  localparam int MOPT_CLKSEL_BIT = 7;
  localparam int MOPT_PROT_BIT = 4;
  localparam int MOPT_REV_BIT = 3;
  localparam int CTRL_ERASE_BIT = 2;
  localparam int CTRL_AUTO_BIT = 1;
  localparam int CTRL_GO_BIT = 0;
  localparam int DIV_W = 11;
  localparam int DIV_HI_W = 3;

  // Reset values
  localparam logic [7:0] SHADOW_RST = 8'h00;
  localparam logic [7:0] REG_RST = 8'h00;

  // Timing: core rate and the longest auto durations
  localparam int CLK_MHZ = 40;
  localparam int PGM_MAX_US = 500;
  localparam int ERASE_MAX_MS = 8;
  localparam int PGM_MAX_CYC = PGM_MAX_US * CLK_MHZ;
  localparam int ERASE_MAX_CYC = ERASE_MAX_MS * 1000 * CLK_MHZ;
  localparam int PGM_TICKS = 16;
  localparam int ERASE_TICKS = 256;
  localparam int ALT_REF_DIV = 4;

  // Auto timing engine state
  typedef enum logic [0:0] {
    ETAC_IDLE = 1'b0,
    ETAC_RUN  = 1'b1
  } etac_st_t;
endpackage

// ---- hw/etac_top.sv ----
// EEPROM timebase divider, auto program/erase timing and mask option register
`timescale 1ns/100ps

// What this block does
// (RQ1) Option bit 7 picks divider reference clock
// (RQ2) Eleven-bit divide value over high/low registers
// (RQ3) Dividers and config reload from shadows on reset
// (RQ4) Control bit 7 has no function
// (RQ5) Control bit 1 enables automatic timing
// (RQ6) Auto mode times operation, clears go bit
// (RQ7) Software sets go, then polls it clear
// (RQ8) Programmed bit reads 0, erased reads 1
// (RQ9) Option bit 4 read-protects arrays in monitor
// (RQ10) Option bit 3 fixed high as revision mark
// (RQ11) Option register has only bits 7, 4, 3
// (RQ12) Auto program ends within 500 us
// (RQ13) Auto erase ends within 8 ms
// (RQ14) Manual mode: go stays until software clears
// (RQ15) Divider ticks each time divide value reached
module etac_top #(
  parameter int PGM_MAX_CYC   = etac_pkg::PGM_MAX_CYC,
  parameter int ERASE_MAX_CYC = etac_pkg::ERASE_MAX_CYC,
  parameter int PGM_TICKS     = etac_pkg::PGM_TICKS,
  parameter int ERASE_TICKS   = etac_pkg::ERASE_TICKS,
  parameter int ALT_REF_DIV   = etac_pkg::ALT_REF_DIV
) (
  input  wire logic        CORE_CLK,
  input  wire logic        RSTN,
  input  wire logic        PORN,
  input  wire logic [15:0] ADDR,
  input  wire logic [7:0]  WDATA,
  input  wire logic        WR,
  input  wire logic        RD,
  output logic      [7:0]  RDATA,
  input  wire logic        MON_MODE,
  output logic             IRQ,
  output logic             READ_PROTECT,
  output logic      [1:0]  HV_PGM,
  output logic      [1:0]  HV_ERASE,
  output logic      [1:0]  TB_TICK
);

  // Eleven-bit divide value from the two halves
  function automatic logic [10:0] div_v(input logic [7:0] hi, input logic [7:0] lo);
    div_v = {hi[etac_pkg::DIV_HI_W-1:0], lo}; // RQ2
  endfunction

  logic                 clksel_r;
  logic                 prot_r;
  logic                 mon_s1_r;
  logic                 mon_s2_r;
  logic                 load_r;
  logic [7:0]           sh_hi_r [2];
  logic [7:0]           sh_lo_r [2];
  logic [7:0]           sh_cfg_r [2];
  logic [7:0]           div_hi_r [2];
  logic [7:0]           div_lo_r [2];
  logic [7:0]           cfg_act_r [2];
  logic [1:0]           go_r;
  logic [1:0]           auto_r;
  logic [1:0]           erase_r;
  logic [10:0]          tb_cnt_r [2];
  logic [11:0]          tk_cnt_r [2];
  logic [18:0]          cyc_r [2];
  etac_pkg::etac_st_t   st_r [2];
  logic [15:0]          alt_cnt_r;
  logic                 ref_en;
  logic [1:0]           tb_hit;
  logic [1:0]           done;
  logic [1:0]           ist_r;
  logic [1:0]           ien_r;
  logic [7:0]           rd_nxt;
  logic [10:0]          div0;

  // Monitor mode pin comes from outside, two flops first
  always_ff @(posedge CORE_CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      mon_s1_r <= 1'b0;
      mon_s2_r <= 1'b0;
    end
    else
    begin
      mon_s1_r <= MON_MODE;
      mon_s2_r <= mon_s1_r;
    end
  end

  // Mask option bits, software selectable
  always_ff @(posedge CORE_CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      clksel_r <= 1'b0;
      prot_r <= 1'b0;
    end
    else if (WR && ADDR == etac_pkg::MOPT_OFS)
    begin
      clksel_r <= WDATA[etac_pkg::MOPT_CLKSEL_BIT]; // RQ1
      prot_r <= WDATA[etac_pkg::MOPT_PROT_BIT]; // RQ9
    end
  end

  // Shadows survive core reset, only power-on clears them
  always_ff @(posedge CORE_CLK or negedge PORN)
  begin
    if (!PORN)
    begin
      for (int i = 0; i < etac_pkg::NARR; i++)
      begin
        sh_hi_r[i] <= etac_pkg::SHADOW_RST;
        sh_lo_r[i] <= etac_pkg::SHADOW_RST;
        sh_cfg_r[i] <= etac_pkg::SHADOW_RST;
      end
    end
    else if (WR)
    begin
      for (int i = 0; i < etac_pkg::NARR; i++)
      begin
        if (ADDR == etac_pkg::DIVHS_OFS[i])
          sh_hi_r[i] <= WDATA;
        if (ADDR == etac_pkg::DIVLS_OFS[i])
          sh_lo_r[i] <= WDATA;
        if (ADDR == etac_pkg::CFGS_OFS[i])
          sh_cfg_r[i] <= WDATA;
      end
    end
  end

  // Reload pending flag; async reset cannot copy a signal, so copy on release
  always_ff @(posedge CORE_CLK or negedge RSTN)
  begin
    if (!RSTN)
      load_r <= 1'b1;
    else
      load_r <= 1'b0;
  end

  // Volatile dividers and active config
  always_ff @(posedge CORE_CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      for (int i = 0; i < etac_pkg::NARR; i++)
      begin
        div_hi_r[i] <= etac_pkg::REG_RST;
        div_lo_r[i] <= etac_pkg::REG_RST;
        cfg_act_r[i] <= etac_pkg::REG_RST;
      end
    end
    else
    begin
      for (int i = 0; i < etac_pkg::NARR; i++)
      begin
        if (load_r)
        begin
          div_hi_r[i] <= sh_hi_r[i]; // RQ3
          div_lo_r[i] <= sh_lo_r[i]; // RQ3
          cfg_act_r[i] <= sh_cfg_r[i]; // RQ3
        end
        else if (WR && ADDR == etac_pkg::DIVH_OFS[i])
          div_hi_r[i] <= WDATA;
        else if (WR && ADDR == etac_pkg::DIVL_OFS[i])
          div_lo_r[i] <= WDATA;
      end
    end
  end

  // Alternate reference: divided core clock as an enable pulse
  always_ff @(posedge CORE_CLK or negedge RSTN)
  begin
    if (!RSTN)
      alt_cnt_r <= 16'h0000;
    else if (alt_cnt_r == 16'(ALT_REF_DIV - 1))
      alt_cnt_r <= 16'h0000;
    else
      alt_cnt_r <= alt_cnt_r + 16'h0001;
  end

  assign ref_en = clksel_r ? (alt_cnt_r == 16'(ALT_REF_DIV - 1)) : 1'b1; // RQ1
  assign div0 = div_v(div_hi_r[0], div_lo_r[0]);

  // Timebase: wrap and tick when the count meets the divide value
  always_comb
  begin
    for (int i = 0; i < etac_pkg::NARR; i++)
      tb_hit[i] = ref_en && (tb_cnt_r[i] == div_v(div_hi_r[i], div_lo_r[i])); // RQ15
  end

  always_ff @(posedge CORE_CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      TB_TICK <= 2'b00;
      for (int i = 0; i < etac_pkg::NARR; i++)
        tb_cnt_r[i] <= 11'h000;
    end
    else
    begin
      TB_TICK <= tb_hit; // RQ15
      for (int i = 0; i < etac_pkg::NARR; i++)
      begin
        if (tb_hit[i])
          tb_cnt_r[i] <= 11'h000;
        else if (ref_en)
          tb_cnt_r[i] <= tb_cnt_r[i] + 11'h001;
      end
    end
  end

  // Auto completion: enough ticks, or the wall-clock ceiling as a backstop
  always_comb
  begin
    for (int i = 0; i < etac_pkg::NARR; i++)
    begin
      done[i] = 1'b0;
      if (st_r[i] == etac_pkg::ETAC_RUN && go_r[i] && auto_r[i])
      begin
        if (erase_r[i])
          done[i] = (tb_hit[i] && tk_cnt_r[i] == 12'(ERASE_TICKS - 1))
                    || (cyc_r[i] == 19'(ERASE_MAX_CYC - 2)); // RQ13
        else
          done[i] = (tb_hit[i] && tk_cnt_r[i] == 12'(PGM_TICKS - 1))
                    || (cyc_r[i] == 19'(PGM_MAX_CYC - 2)); // RQ12
      end
    end
  end

  // Engine state per array
  always_ff @(posedge CORE_CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      for (int i = 0; i < etac_pkg::NARR; i++)
      begin
        st_r[i] <= etac_pkg::ETAC_IDLE;
        tk_cnt_r[i] <= 12'h000;
        cyc_r[i] <= 19'h0_0000;
      end
    end
    else
    begin
      for (int i = 0; i < etac_pkg::NARR; i++)
      begin
        case (st_r[i])
          etac_pkg::ETAC_IDLE:
          begin
            tk_cnt_r[i] <= 12'h000;
            cyc_r[i] <= 19'h0_0000;
            if (go_r[i] && auto_r[i])
              st_r[i] <= etac_pkg::ETAC_RUN; // RQ6
          end
          etac_pkg::ETAC_RUN:
          begin
            cyc_r[i] <= cyc_r[i] + 19'h0_0001;
            if (tb_hit[i])
              tk_cnt_r[i] <= tk_cnt_r[i] + 12'h001;
            // Software abort or auto dropped ends the timed run
            if (done[i] || !go_r[i] || !auto_r[i])
              st_r[i] <= etac_pkg::ETAC_IDLE;
          end
          default:
            st_r[i] <= etac_pkg::ETAC_IDLE;
        endcase
      end
    end
  end

  // Control register; bit 7 and other bits are not stored
  always_ff @(posedge CORE_CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      go_r <= 2'b00;
      auto_r <= 2'b00;
      erase_r <= 2'b00;
    end
    else
    begin
      for (int i = 0; i < etac_pkg::NARR; i++)
      begin
        if (WR && ADDR == etac_pkg::CTRL_OFS[i])
        begin
          auto_r[i] <= WDATA[etac_pkg::CTRL_AUTO_BIT]; // RQ5
          erase_r[i] <= WDATA[etac_pkg::CTRL_ERASE_BIT];
        end
        // Hardware clear wins so a late rewrite cannot restart silently
        if (done[i])
          go_r[i] <= 1'b0; // RQ6
        else if (WR && ADDR == etac_pkg::CTRL_OFS[i])
          go_r[i] <= WDATA[etac_pkg::CTRL_GO_BIT]; // RQ14
      end
    end
  end

  // Array drive: erase takes cells to 1, program pulls them to 0
  always_ff @(posedge CORE_CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      HV_PGM <= 2'b00;
      HV_ERASE <= 2'b00;
    end
    else
    begin
      HV_PGM <= go_r & ~erase_r & ~done; // RQ8
      HV_ERASE <= go_r & erase_r & ~done; // RQ8
    end
  end

  // Read protection in monitor mode
  always_ff @(posedge CORE_CLK or negedge RSTN)
  begin
    if (!RSTN)
      READ_PROTECT <= 1'b0;
    else
      READ_PROTECT <= mon_s2_r && prot_r; // RQ9
  end

  // Sticky completion events; a set in the clear cycle survives
  always_ff @(posedge CORE_CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      ist_r <= 2'b00;
      ien_r <= 2'b00;
      IRQ <= 1'b0;
    end
    else
    begin
      if (WR && ADDR == etac_pkg::ICLR_OFS)
        ist_r <= (ist_r & ~WDATA[1:0]) | done;
      else
        ist_r <= ist_r | done;
      if (WR && ADDR == etac_pkg::IEN_OFS)
        ien_r <= WDATA[1:0];
      IRQ <= |(ist_r & ien_r);
    end
  end

  // Read mux; unmapped and write-only locations read zero
  always_comb
  begin
    rd_nxt = 8'h00;
    if (ADDR == etac_pkg::MOPT_OFS)
    begin
      rd_nxt[etac_pkg::MOPT_CLKSEL_BIT] = clksel_r; // RQ11
      rd_nxt[etac_pkg::MOPT_PROT_BIT] = prot_r; // RQ11
      rd_nxt[etac_pkg::MOPT_REV_BIT] = 1'b1; // RQ10
    end
    if (ADDR == etac_pkg::IST_OFS)
      rd_nxt = {6'h00, ist_r};
    if (ADDR == etac_pkg::IEN_OFS)
      rd_nxt = {6'h00, ien_r};
    for (int i = 0; i < etac_pkg::NARR; i++)
    begin
      if (ADDR == etac_pkg::DIVHS_OFS[i])
        rd_nxt = sh_hi_r[i];
      if (ADDR == etac_pkg::DIVLS_OFS[i])
        rd_nxt = sh_lo_r[i];
      if (ADDR == etac_pkg::CFGS_OFS[i])
        rd_nxt = sh_cfg_r[i];
      if (ADDR == etac_pkg::DIVH_OFS[i])
        rd_nxt = div_hi_r[i];
      if (ADDR == etac_pkg::DIVL_OFS[i])
        rd_nxt = div_lo_r[i];
      if (ADDR == etac_pkg::CFGA_OFS[i])
        rd_nxt = cfg_act_r[i];
      if (ADDR == etac_pkg::CTRL_OFS[i]) // RQ4
      begin
        rd_nxt[etac_pkg::CTRL_ERASE_BIT] = erase_r[i];
        rd_nxt[etac_pkg::CTRL_AUTO_BIT] = auto_r[i];
        rd_nxt[etac_pkg::CTRL_GO_BIT] = go_r[i]; // RQ7
      end
    end
  end

  // Data stands only in the cycle after the strobe
  always_ff @(posedge CORE_CLK or negedge RSTN)
  begin
    if (!RSTN)
      RDATA <= 8'h00;
    else if (RD)
      RDATA <= rd_nxt;
    else
      RDATA <= 8'h00;
  end

  // Checks on array 1; array 2 shares the same code
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (!RSTN);

  AST_REV_BIT: assert property (RD && ADDR == etac_pkg::MOPT_OFS |=> RDATA[3]) // RQ10
    else $error("revision bit not set");
  AST_OPT_UNUSED: assert property (RD && ADDR == etac_pkg::MOPT_OFS // RQ11
    |=> RDATA[6:5] == 2'b00 && RDATA[2:0] == 3'b000)
    else $error("unused option bit set");
  AST_LEGACY_B7: assert property (RD && ADDR == etac_pkg::CTRL_OFS[0] |=> !RDATA[7]) // RQ4
    else $error("control bit 7 reads high");
  AST_AUTO_POS: assert property (WR && ADDR == etac_pkg::CTRL_OFS[0] // RQ5
    |=> auto_r[0] == $past(WDATA[1]))
    else $error("auto bit not at position 1");
  AST_AUTO_CLEAR: assert property (done[0] |=> !go_r[0] ##1 !HV_PGM[0] && !HV_ERASE[0]) // RQ6
    else $error("go not cleared after completion");
  AST_MANUAL_HOLD: assert property (go_r[0] && !auto_r[0] // RQ14
    && !(WR && ADDR == etac_pkg::CTRL_OFS[0]) |=> go_r[0])
    else $error("manual go dropped by hardware");
  AST_PGM_BOUND: assert property (st_r[0] == etac_pkg::ETAC_RUN && !erase_r[0] // RQ12
    |-> cyc_r[0] <= 19'(PGM_MAX_CYC - 2))
    else $error("program exceeds ceiling");
  AST_ERASE_BOUND: assert property (st_r[0] == etac_pkg::ETAC_RUN && erase_r[0] // RQ13
    |-> cyc_r[0] <= 19'(ERASE_MAX_CYC - 2))
    else $error("erase exceeds ceiling");
  AST_RELOAD: assert property (load_r |=> div_hi_r[0] == $past(sh_hi_r[0]) // RQ3
    && div_lo_r[0] == $past(sh_lo_r[0]) && cfg_act_r[0] == $past(sh_cfg_r[0]))
    else $error("reload from shadow missing");
  AST_TICK: assert property (TB_TICK[0] |-> $past(tb_cnt_r[0]) == $past(div0)) // RQ15
    else $error("tick without reaching divide value");
  // Select must hold a second cycle, else a switch back to core rate looks like a miss
  AST_CLKSEL: assert property (clksel_r && ref_en ##1 clksel_r |-> !ref_en) // RQ1
    else $error("alternate reference not divided");
  AST_PROTECT: assert property ($rose(READ_PROTECT) |-> $past(prot_r) && $past(mon_s2_r)) // RQ9
    else $error("protect without monitor and option");
  AST_IRQ: assert property (|(ist_r & ien_r) |=> IRQ)
    else $error("interrupt not raised");

  COV_AUTO_PGM: cover property (done[0] && !erase_r[0]);
  COV_AUTO_ERASE: cover property (done[0] && erase_r[0]);
  COV_MANUAL: cover property (go_r[0] && !auto_r[0] ##4 !go_r[0]);
  COV_IRQ: cover property ($rose(IRQ));

endmodule // etac_top

// ---- verification/etac_bench.sv ----
// Self-checking bench for the EEPROM timebase and auto timing block
`timescale 1ns/100ps
module etac_bench;
  localparam int PMAX = 40;
  localparam int EMAX = 80;
  logic        clk      = 1'b0;
  logic        rstn     = 1'b0;
  logic        porn     = 1'b0;
  logic [15:0] addr     = 16'h0000;
  logic [7:0]  wdata    = 8'h00;
  logic        wr       = 1'b0;
  logic        rd       = 1'b0;
  logic        mon      = 1'b0;
  logic [7:0]  rdata;
  logic        irq;
  logic        rprot;
  logic [1:0]  hv_pgm;
  logic [1:0]  hv_erase;
  logic [1:0]  tick;
  logic [7:0]  cell0;
  logic [7:0]  cell1;
  int          mismatches = 0;
  int          n_tests    = 0;
  int          cyc        = 0;

  // 40 MHz core clock and a free cycle count for elapsed-time checks
  always #12.5 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;

  // Short counts keep auto runs brief; expectations use PMAX and EMAX
  etac_top #(.PGM_MAX_CYC(PMAX), .ERASE_MAX_CYC(EMAX), .PGM_TICKS(4), .ERASE_TICKS(8),
    .ALT_REF_DIV(4)) DUT (.CORE_CLK(clk), .RSTN(rstn), .PORN(porn), .ADDR(addr),
    .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .MON_MODE(mon), .IRQ(irq),
    .READ_PROTECT(rprot), .HV_PGM(hv_pgm), .HV_ERASE(hv_erase), .TB_TICK(tick));

  etac_cell_model cells (.clk(clk), .hv_pgm(hv_pgm), .hv_erase(hv_erase), .cell0(cell0),
    .cell1(cell1));

  // Closing report, the only place the run ends
  task print_verdict;
    $display("mismatches=%0d comparisons=%0d", mismatches, n_tests);
    if (mismatches == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task chk(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task timeout;
    mismatches++;
    $display("mismatch at %0t: wait ran out", $time);
    print_verdict;
  endtask

  // Bus cycles; strobe dropped at the next edge, so calls never collide
  task wrr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task rdr(input logic [15:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask

  task rdc(input logic [15:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rdr(a, d);
    chk({8'h00, d}, {8'h00, exp});
  endtask

  task cw(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // Cycles up to and including the next tick of array i
  task wait_tick(input int i, output int n);
    n = 0;
    do
    begin
      @(posedge clk);
      #1 n++;
    end
    while (tick[i] !== 1'b1 && n < 9000);
    if (n >= 9000)
      timeout;
  endtask

  task period(input int i, input int exp);
    int n;
    wait_tick(i, n);
    wait_tick(i, n);
    chk(n[15:0], exp[15:0]);
  endtask

  // Software side of auto mode: poll go until hardware clears it
  task poll(input logic [15:0] a, output int el);
    logic [7:0] d;
    int         t0;
    t0 = cyc;
    d  = 8'h01;
    while (d[0] !== 1'b0 && cyc - t0 < 400)
      rdr(a, d);
    el = cyc - t0;
    if (d[0] !== 1'b0)
      timeout;
  endtask

  // Reset values, shadow reload on core reset, read-only active config
  task t_reset;
    rdc(etac_pkg::MOPT_OFS, 8'h08);
    rdc(etac_pkg::DIVH_OFS[0], 8'h00);
    wrr(etac_pkg::DIVHS_OFS[0], 8'h05);
    wrr(etac_pkg::DIVLS_OFS[0], 8'h21);
    wrr(etac_pkg::CFGS_OFS[0], 8'h5A);
    wrr(etac_pkg::DIVHS_OFS[1], 8'h02);
    wrr(etac_pkg::DIVLS_OFS[1], 8'h10);
    wrr(etac_pkg::DIVH_OFS[0], 8'h07);
    @(posedge clk);
    rstn <= 1'b0;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    repeat (2) @(posedge clk);
    rdc(etac_pkg::DIVH_OFS[0], 8'h05);
    rdc(etac_pkg::DIVL_OFS[0], 8'h21);
    rdc(etac_pkg::CFGA_OFS[0], 8'h5A);
    rdc(etac_pkg::DIVH_OFS[1], 8'h02);
    rdc(etac_pkg::DIVL_OFS[1], 8'h10);
    wrr(etac_pkg::CFGA_OFS[0], 8'h33);
    rdc(etac_pkg::CFGA_OFS[0], 8'h5A);
  endtask

  // Option register layout and monitor-mode read protection
  task t_mask_option_b;
    wrr(etac_pkg::MOPT_OFS, 8'hFF);
    rdc(etac_pkg::MOPT_OFS, 8'h98);
    cw(4);
    chk(rprot, 1'b0);
    @(posedge clk);
    mon <= 1'b1;
    cw(5);
    chk(rprot, 1'b1);
    wrr(etac_pkg::MOPT_OFS, 8'h00);
    cw(3);
    chk(rprot, 1'b0);
    rdc(etac_pkg::MOPT_OFS, 8'h08);
    @(posedge clk);
    mon <= 1'b0;
  endtask

  // Control layout, unmapped and write-only places
  task t_ctrl;
    wrr(etac_pkg::CTRL_OFS[0], 8'h80);
    rdc(etac_pkg::CTRL_OFS[0], 8'h00);
    wrr(etac_pkg::CTRL_OFS[1], 8'h02);
    rdc(etac_pkg::CTRL_OFS[1], 8'h02);
    wrr(etac_pkg::CTRL_OFS[1], 8'h00);
    wrr(16'hFE0A, 8'hFF);
    rdc(16'hFE0A, 8'h00);
    rdc(etac_pkg::ICLR_OFS, 8'h00);
  endtask

  // Tick period is (divide value + 1) reference cycles
  task t_tick;
    wrr(etac_pkg::DIVH_OFS[0], 8'h08);
    wrr(etac_pkg::DIVL_OFS[0], 8'h02);
    period(0, 3);
    wrr(etac_pkg::DIVH_OFS[1], 8'h01);
    wrr(etac_pkg::DIVL_OFS[1], 8'h00);
    period(1, 257);
    wrr(etac_pkg::DIVL_OFS[0], 8'h03);
    period(0, 4);
    wrr(etac_pkg::MOPT_OFS, 8'h80);
    period(0, 16);
    wrr(etac_pkg::MOPT_OFS, 8'h00);
  endtask

  // Auto program with ticks too slow, so the time bound must end it
  task t_auto_pgm;
    int el;
    wrr(etac_pkg::IEN_OFS, 8'h03);
    wrr(etac_pkg::DIVH_OFS[0], 8'h07);
    wrr(etac_pkg::DIVL_OFS[0], 8'hFF);
    wrr(etac_pkg::CTRL_OFS[0], 8'h03);
    cw(1);
    chk(hv_pgm[0], 1'b1);
    chk(hv_erase[0], 1'b0);
    poll(etac_pkg::CTRL_OFS[0], el);
    chk(16'(el <= PMAX + 4), 16'h0001);
    cw(2);
    chk(irq, 1'b1);
    chk(hv_pgm[0], 1'b0);
    chk(cell0, 8'h00);
    rdc(etac_pkg::IST_OFS, 8'h01);
    wrr(etac_pkg::IEN_OFS, 8'h00);
    cw(2);
    chk(irq, 1'b0);
    wrr(etac_pkg::ICLR_OFS, 8'h01);
    rdc(etac_pkg::IST_OFS, 8'h00);
    wrr(etac_pkg::IEN_OFS, 8'h03);
    cw(2);
    chk(irq, 1'b0);
  endtask

  // Auto erase: second array ended by ticks, first array by the time bound
  task t_auto_erase;
    int el;
    int n;
    wrr(etac_pkg::DIVL_OFS[1], 8'h03);
    wrr(etac_pkg::DIVH_OFS[1], 8'h00);
    // Counter may sit above the new value; one tick puts it back at zero
    wait_tick(1, n);
    wrr(etac_pkg::CTRL_OFS[1], 8'h07);
    cw(1);
    chk(hv_erase[1], 1'b1);
    chk(hv_pgm[1], 1'b0);
    poll(etac_pkg::CTRL_OFS[1], el);
    chk(16'(el <= EMAX + 4), 16'h0001);
    chk(16'(el <= 8 * 4 + 4), 16'h0001);
    cw(2);
    chk(irq, 1'b1);
    chk(cell1, 8'hFF);
    rdc(etac_pkg::IST_OFS, 8'h02);
    wrr(etac_pkg::CTRL_OFS[0], 8'h07);
    cw(1);
    chk(hv_erase[0], 1'b1);
    poll(etac_pkg::CTRL_OFS[0], el);
    chk(16'(el <= EMAX + 4), 16'h0001);
    cw(2);
    chk(cell0, 8'hFF);
    rdc(etac_pkg::IST_OFS, 8'h03);
    wrr(etac_pkg::ICLR_OFS, 8'h03);
  endtask

  // Manual mode: go outlives every auto bound until software drops it
  task t_manual;
    wrr(etac_pkg::CTRL_OFS[0], 8'h01);
    cw(3 * PMAX);
    rdc(etac_pkg::CTRL_OFS[0], 8'h01);
    chk(hv_pgm[0], 1'b1);
    rdc(etac_pkg::IST_OFS, 8'h00);
    wrr(etac_pkg::CTRL_OFS[0], 8'h00);
    rdc(etac_pkg::CTRL_OFS[0], 8'h00);
  endtask

  // Both resets together so the shadows start defined
  initial
  begin
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    porn <= 1'b1;
    repeat (2) @(posedge clk);
    t_reset;
    t_mask_option_b;
    t_ctrl;
    t_tick;
    t_auto_pgm;
    t_auto_erase;
    t_manual;
    print_verdict;
  end
endmodule // etac_bench

// ---- verification/etac_cell_model.sv ----
// Behavioural model of the two EEPROM bit-cell arrays behind the block
`timescale 1ns/100ps
module etac_cell_model (
  input  wire logic       clk,
  input  wire logic [1:0] hv_pgm,
  input  wire logic [1:0] hv_erase,
  output logic      [7:0] cell0,
  output logic      [7:0] cell1
);
  // Non-volatile, so no reset; start on a pattern that neither drive makes
  initial
  begin
    cell0 = 8'hA5;
    cell1 = 8'hA5;
  end

  // Erase pulls every bit to 1, program to 0
  always @(posedge clk)
  begin
    if (hv_erase[0])
      cell0 <= 8'hFF;
    else if (hv_pgm[0])
      cell0 <= 8'h00;
    if (hv_erase[1])
      cell1 <= 8'hFF;
    else if (hv_pgm[1])
      cell1 <= 8'h00;
  end
endmodule // etac_cell_model
